// File: stm_top.v
`timescale 1ns/1ps
`include "stm_regs.vh"
// Traffic manager: classification, admission, per-port scheduling and remote multicast queue.
module stm_top #(
  parameter NP = 12,
  parameter HW = 8,
  parameter CW = 8,
  parameter QPW = 3,
  parameter MPW = 3,
  parameter MRSV = 2
) (
  // Clock and reset.
  input wire mclk,
  input wire rst_n,
  // AHB-Lite register slave.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Received frame descriptor.
  input wire rx_valid,
  input wire [2:0] rx_pcp,
  input wire [47:0] rx_dst_mac,
  input wire rx_is_ip,
  input wire [7:0] rx_ip_proto,
  input wire [31:0] rx_dst_ip,
  input wire rx_multicast,
  input wire rx_lookup_hit,
  input wire [NP-1:0] rx_dst_ports,
  input wire [NP-1:0] rx_vlan_ports,
  input wire rx_remote,
  input wire [HW-1:0] rx_handle,
  input wire free_buf_none,
  // Admission result.
  output reg adm_valid,
  output reg [NP-1:0] adm_ports,
  output reg adm_remote,
  output reg [1:0] adm_class,
  output reg adm_drop,
  output reg adm_to_cpu,
  output reg adm_ip_multicast_frame,
  // Buffer release.
  input wire rel_valid,
  input wire [NP-1:0] rel_ports,
  input wire rel_mc,
  // Port transmit jobs.
  input wire [NP-1:0] tx_req,
  output wire [NP-1:0] tx_valid,
  output wire [NP*HW-1:0] tx_handle,
  output wire [NP*2-1:0] tx_class,
  // Remote multicast pipe.
  output wire rmt_valid,
  output wire [HW-1:0] rmt_handle,
  input wire rmt_ready,
  input wire rmt_done
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [15:0] priority_map_reg;
  reg [10:0] queue_weight_reg;
  reg [15:0] buffer_threshold_pair;
  reg [NP-1:0] per_port_threshold_select;
  reg [15:0] multicast_buffer_limit;
  reg [31:0] ip_multicast_frame_signature_low;
  reg [15:0] ip_multicast_frame_signature_high;
  reg [31:0] ip_multicast_frame_mask_low;
  reg [15:0] ip_multicast_frame_mask_high;
  reg [31:0] device_config_word;
  reg [CW-1:0] cnt_q [0:NP-1];
  reg [7:0] mc_held_q;
  reg [2:0] inflight_q;
  reg [7:0] drop_cnt_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg [31:0] rd_d;
  integer p;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  wire ahb_go;
  wire [3:0] cnt_idx;
  wire [MPW:0] mcq_count;

  // Every transfer completes with no wait state and an OKAY answer.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ahb_go = hsel && htrans[1] && hready;
  assign cnt_idx = haddr[5:2];

  // Read data is chosen in the address phase and registered into the data phase.
  always @* begin
    rd_d = 32'h00000000;
    case (haddr[7:0])
      `STM_A_PRIO_MAP: rd_d = {16'h0000, priority_map_reg};
      `STM_A_QUEUE_WEIGHT: rd_d = {21'h000000, queue_weight_reg};
      `STM_A_BUF_THR: rd_d = {16'h0000, buffer_threshold_pair};
      `STM_A_THR_SEL: rd_d = {{(32-NP){1'b0}}, per_port_threshold_select};
      `STM_A_MC_LIMIT: rd_d = {16'h0000, multicast_buffer_limit};
      `STM_A_SIG_LO: rd_d = ip_multicast_frame_signature_low;
      `STM_A_SIG_HI: rd_d = {16'h0000, ip_multicast_frame_signature_high};
      `STM_A_MSK_LO: rd_d = ip_multicast_frame_mask_low;
      `STM_A_MSK_HI: rd_d = {16'h0000, ip_multicast_frame_mask_high};
      `STM_A_DEV_CFG: rd_d = device_config_word;
      `STM_A_STATUS: rd_d = {drop_cnt_q, {(12-MPW){1'b0}}, inflight_q, mcq_count, mc_held_q};
      default: begin
        if (haddr[7:6] == `STM_A_CNT_BASE && cnt_idx < NP) begin
          rd_d = {{(32-CW){1'b0}}, cnt_q[cnt_idx]};
        end
      end
    endcase
  end

  // Writes land in the data phase at the address captured one cycle earlier.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h00000000;
      priority_map_reg <= `STM_R_PRIO_MAP;
      queue_weight_reg <= `STM_R_QUEUE_WEIGHT;
      buffer_threshold_pair <= `STM_R_BUF_THR;
      per_port_threshold_select <= {NP{1'b0}};
      multicast_buffer_limit <= `STM_R_MC_LIMIT;
      ip_multicast_frame_signature_low <= `STM_R_SIG_LO;
      ip_multicast_frame_signature_high <= `STM_R_SIG_HI;
      ip_multicast_frame_mask_low <= `STM_R_MSK_LO;
      ip_multicast_frame_mask_high <= `STM_R_MSK_HI;
      device_config_word <= 32'h00000000; // Recognition off after reset.
    end else begin
      wr_pend_q <= ahb_go && hwrite;
      wr_addr_q <= haddr[7:0];
      if (ahb_go && !hwrite) begin
        hrdata <= rd_d;
      end
      if (wr_pend_q) begin
        case (wr_addr_q)
          `STM_A_PRIO_MAP: priority_map_reg <= hwdata[15:0];
          `STM_A_QUEUE_WEIGHT: queue_weight_reg <= hwdata[10:0];
          `STM_A_BUF_THR: buffer_threshold_pair <= hwdata[15:0];
          `STM_A_THR_SEL: per_port_threshold_select <= hwdata[NP-1:0];
          `STM_A_MC_LIMIT: multicast_buffer_limit <= hwdata[15:0];
          `STM_A_SIG_LO: ip_multicast_frame_signature_low <= hwdata;
          `STM_A_SIG_HI: ip_multicast_frame_signature_high <= hwdata[15:0];
          `STM_A_MSK_LO: ip_multicast_frame_mask_low <= hwdata;
          `STM_A_MSK_HI: ip_multicast_frame_mask_high <= hwdata[15:0];
          `STM_A_DEV_CFG: device_config_word <= hwdata;
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // Classification and recognition
  // ****************************************************************
  wire [1:0] rx_class;
  wire [47:0] sig_full;
  wire [47:0] msk_full;
  wire sig_hit;
  wire ip_multicast_frame_data;
  wire ip_multicast_frame_en;
  wire ip_multicast_frame_priv;
  wire to_cpu;
  wire [NP-1:0] ports_raw;

  // Two map bits per priority value; class 0 is the highest.
  assign rx_class = priority_map_reg[{rx_pcp, 1'b0} +: 2];
  assign sig_full = {ip_multicast_frame_signature_high, ip_multicast_frame_signature_low};
  assign msk_full = {ip_multicast_frame_mask_high, ip_multicast_frame_mask_low};
  // Only mask bits set to one take part in the compare.
  assign sig_hit = (((rx_dst_mac ^ sig_full) & msk_full) == 48'h000000000000);
  // The signature resets to the 01-00-5e prefix; the address range is fixed.
  assign ip_multicast_frame_data = rx_is_ip && sig_hit && rx_dst_ip >= `STM_IP_DATA_LO && rx_dst_ip <= `STM_IP_DATA_HI;
  assign ip_multicast_frame_en = device_config_word[`STM_CFG_IP_MULTICAST_FRAME_EN];
  // With recognition off the privilege never applies.
  assign ip_multicast_frame_priv = ip_multicast_frame_en && ip_multicast_frame_data;
  // Group management traffic is flagged for the processor.
  assign to_cpu = rx_is_ip && ((rx_dst_mac[47:24] == `STM_MAC_IP_MULTICAST_FRAME_PREFIX && rx_ip_proto == `STM_IGMP_PROTO) ||
                  rx_dst_ip[31:8] == `STM_IP_LOCAL_PREFIX);
  // An unknown IP multicast group floods its VLAN.
  assign ports_raw = (ip_multicast_frame_data && !rx_lookup_hit) ? rx_vlan_ports : rx_dst_ports;

  // ****************************************************************
  // Admission
  // ****************************************************************
  wire [8:0] mc_lim_l2;
  wire [8:0] mc_lim_ip;
  wire mc_block;
  wire drop_all;
  wire [NP-1:0] port_ok;
  wire [NP-1:0] q_full;
  wire [NP-1:0] ports_adm;
  wire mcq_room;
  wire remote_adm;
  wire stored;

  assign mc_lim_l2 = {1'b0, multicast_buffer_limit[7:0]};
  // IP multicast gets extra headroom above the plain multicast limit.
  assign mc_lim_ip = mc_lim_l2 + {1'b0, multicast_buffer_limit[15:8]};
  // The multicast limit keeps the rest of the buffers for unicast.
  assign mc_block = rx_multicast && ({1'b0, mc_held_q} >= (ip_multicast_frame_priv ? mc_lim_ip : mc_lim_l2));
  // No free buffer means the whole frame is discarded.
  assign drop_all = free_buf_none || mc_block;

  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : g_port
      wire [CW-1:0] thr;
      wire [3:0] full_vec;
      // Each port compares its counter with the threshold it selected.
      assign thr = per_port_threshold_select[g] ? buffer_threshold_pair[15:8] : buffer_threshold_pair[7:0];
      assign port_ok[g] = (cnt_q[g] < thr) && !q_full[g];
      assign q_full[g] = full_vec[rx_class];
      stm_psch #(.HW(HW), .PW(QPW)) u_sch (
        .mclk(mclk),
        .rst_n(rst_n),
        .weight_ratio_first(queue_weight_reg[1:0]),
        .weight_ratio_second(queue_weight_reg[5:4]),
        .weight_ratio_third(queue_weight_reg[10:8]),
        .enq(rx_valid && ports_adm[g]),
        .enq_class(rx_class),
        .enq_handle(rx_handle),
        .full(full_vec),
        .tx_req(tx_req[g]),
        .tx_valid(tx_valid[g]),
        .tx_handle(tx_handle[g*HW +: HW]),
        .tx_class(tx_class[g*2 +: 2])
      );
    end
  endgenerate

  assign ports_adm = drop_all ? {NP{1'b0}} : (ports_raw & port_ok);
  // Remote multicast without queue room loses only its remote part.
  assign remote_adm = rx_remote && !drop_all && (!rx_multicast || mcq_room);
  assign stored = (ports_adm != {NP{1'b0}}) || remote_adm;

  // Descriptor outcome, one cycle after the frame is offered.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      adm_valid <= 1'b0;
      adm_ports <= {NP{1'b0}};
      adm_remote <= 1'b0;
      adm_class <= 2'h0;
      adm_drop <= 1'b0;
      adm_to_cpu <= 1'b0;
      adm_ip_multicast_frame <= 1'b0;
    end else begin
      adm_valid <= rx_valid;
      if (rx_valid) begin
        adm_ports <= ports_adm;
        adm_remote <= remote_adm;
        adm_class <= rx_class;
        adm_drop <= !stored;
        adm_to_cpu <= to_cpu;
        adm_ip_multicast_frame <= ip_multicast_frame_data;
      end
    end
  end

  // ****************************************************************
  // Buffer counters
  // ****************************************************************
  // Count up on store and down on release; both in one cycle cancel out.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (p = 0; p < NP; p = p + 1) begin
        cnt_q[p] <= {CW{1'b0}};
      end
      mc_held_q <= 8'h00;
      drop_cnt_q <= 8'h00;
    end else begin
      for (p = 0; p < NP; p = p + 1) begin
        if ((rx_valid && ports_adm[p]) && !(rel_valid && rel_ports[p] && cnt_q[p] != 0)) begin
          cnt_q[p] <= cnt_q[p] + 1'b1;
        end else if (!(rx_valid && ports_adm[p]) && rel_valid && rel_ports[p] && cnt_q[p] != 0) begin
          cnt_q[p] <= cnt_q[p] - 1'b1;
        end
      end
      // Held multicast frames, released by the buffer manager.
      if ((rx_valid && rx_multicast && stored) && !(rel_mc && mc_held_q != 8'h00)) begin
        mc_held_q <= mc_held_q + 1'b1;
      end else if (!(rx_valid && rx_multicast && stored) && rel_mc && mc_held_q != 8'h00) begin
        mc_held_q <= mc_held_q - 1'b1;
      end
      // Saturating count of frames dropped whole, for software statistics.
      if (rx_valid && !stored && drop_cnt_q != 8'hff) begin
        drop_cnt_q <= drop_cnt_q + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Remote multicast pipe
  // ****************************************************************
  wire mcq_empty;
  wire rmt_take;

  stm_mcq #(.HW(HW), .PW(MPW), .RSV(MRSV)) u_mcq (
    .mclk(mclk),
    .rst_n(rst_n),
    .push(rx_valid && rx_multicast && remote_adm),
    .push_priv(ip_multicast_frame_priv),
    .rsv_en(device_config_word[`STM_CFG_MCQ_RSV]),
    .din(rx_handle),
    .room(mcq_room),
    .pop(rmt_take),
    .dout(rmt_handle),
    .empty(mcq_empty),
    .count(mcq_count)
  );

  // Only a few jobs cross at once; the rest wait in the queue.
  assign rmt_valid = !mcq_empty && inflight_q < `STM_MC_INFLIGHT;
  assign rmt_take = rmt_valid && rmt_ready;

  // In-flight count, up on a job taken and down on a job finished.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      inflight_q <= 3'h0;
    end else if (rmt_take && !(rmt_done && inflight_q != 3'h0)) begin
      inflight_q <= inflight_q + 1'b1;
    end else if (!rmt_take && rmt_done && inflight_q != 3'h0) begin
      inflight_q <= inflight_q - 1'b1;
    end
  end
endmodule

// File: stm_regs.vh
`ifndef STM_REGS_VH
`define STM_REGS_VH
// Summary of operation
// - Every received frame is classified into one of four classes, highest first.
// - Each of eight 802.1p values maps to a class through a writable map.
// - Each port keeps four job queues, one per class, filled by class.
// - A port picks a queue, reads one job, then fetches that frame.
// - Queues are served weighted round robin; weights set adjacent class rate ratios.
// - Each stored frame increments the buffer counter of each destination port.
// - A port whose counter reached its threshold loses further incoming frames.
// - Two thresholds, high and low; a per-port select picks one.
// - With no free frame buffer left, incoming frames are discarded.
// - Multicast frames held in memory are limited by a programmable threshold.
// - Few remote multicast jobs run at once; others wait in the job queue.
// - With the remote job queue full, remote destinations of new multicasts drop.
// - Recognition off after reset; IP multicast is treated as plain multicast. The logic still floods unknown IP multicast groups to the VLAN.
// - Recognition on gives IP multicast buffer priority over plain multicast.
// - IP multicast is recognised by masked compare of destination MAC to signature.
// - Config bit 26 reserves remote job queue space for IP multicast frames.
// - IP multicast data: MAC 01-00-5e and IP within 224.0.1.0..239.255.255.255.
// - Group management frames go to the processor: protocol 2 or IP 224.0.0.x.
// - IP multicast data missing from the address table floods its VLAN.

// Register byte offsets.
`define STM_A_PRIO_MAP 8'h00
`define STM_A_QUEUE_WEIGHT 8'h04
`define STM_A_BUF_THR 8'h08
`define STM_A_THR_SEL 8'h0c
`define STM_A_MC_LIMIT 8'h10
`define STM_A_SIG_LO 8'h14
`define STM_A_SIG_HI 8'h18
`define STM_A_MSK_LO 8'h1c
`define STM_A_MSK_HI 8'h20
`define STM_A_DEV_CFG 8'h24
`define STM_A_STATUS 8'h28
`define STM_A_CNT_BASE 2'b01
// Reset values.
`define STM_R_PRIO_MAP 16'h05af
`define STM_R_QUEUE_WEIGHT 11'h112
`define STM_R_BUF_THR 16'h3020
`define STM_R_MC_LIMIT 16'h0820
`define STM_R_SIG_LO 32'h5e000000
`define STM_R_SIG_HI 16'h0100
`define STM_R_MSK_LO 32'hff800000
`define STM_R_MSK_HI 16'hffff
// Field positions.
`define STM_CFG_IP_MULTICAST_FRAME_EN 25
`define STM_CFG_MCQ_RSV 26
// Protocol constants.
`define STM_MAC_IP_MULTICAST_FRAME_PREFIX 24'h01005e
`define STM_IGMP_PROTO 8'h02
`define STM_IP_LOCAL_PREFIX 24'he00000
`define STM_IP_DATA_LO 32'he0000100
`define STM_IP_DATA_HI 32'hefffffff
`define STM_MC_INFLIGHT 3'h3
`endif

// File: stm_psch.v
`timescale 1ns/1ps
// Per-port scheduler: four class queues of job handles and a weighted round robin picker.
module stm_psch #(
  parameter HW = 8,
  parameter PW = 3
) (
  // Clock and reset.
  input wire mclk,
  input wire rst_n,
  // Weights.
  input wire [1:0] weight_ratio_first,
  input wire [1:0] weight_ratio_second,
  input wire [2:0] weight_ratio_third,
  // Enqueue side.
  input wire enq,
  input wire [1:0] enq_class,
  input wire [HW-1:0] enq_handle,
  output wire [3:0] full,
  // Transmit side.
  input wire tx_req,
  output reg tx_valid,
  output reg [HW-1:0] tx_handle,
  output reg [1:0] tx_class
);
  localparam DEPTH = 1 << PW;
  reg [HW-1:0] mem [0:4*DEPTH-1];
  reg [PW-1:0] wp_q [0:3];
  reg [PW-1:0] rp_q [0:3];
  reg [PW:0] cnt_q [0:3];
  reg [9:0] cr_q [0:3];
  reg [9:0] rl [0:3];
  reg found;
  reg reload;
  reg [1:0] sel;
  integer i;
  integer j;
  wire deq;

  // Reload credits: P2:P3 is linear, the upper two ratios are powers of two.
  always @* begin
    rl[3] = 10'h001;
    rl[2] = (weight_ratio_third == 3'h0) ? 10'h001 : {7'h00, weight_ratio_third};
    rl[1] = rl[2] << weight_ratio_second;
    rl[0] = rl[1] << weight_ratio_first;
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_full
      assign full[g] = cnt_q[g][PW];
    end
  endgenerate

  // Highest class with job and credit wins; empty queues are never picked.
  always @* begin
    found = 1'b0;
    reload = 1'b0;
    sel = 2'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (!found && cnt_q[i] != 0 && cr_q[i] != 0) begin
        found = 1'b1;
        sel = i[1:0];
      end
    end
    for (i = 0; i < 4; i = i + 1) begin
      if (!found && cnt_q[i] != 0) begin
        found = 1'b1;
        reload = 1'b1;
        sel = i[1:0];
      end
    end
  end

  assign deq = tx_req && found;

  // Queue storage, pointers and credits; a job is read before its frame is fetched.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_handle <= {HW{1'b0}};
      tx_class <= 2'h0;
      for (j = 0; j < 4; j = j + 1) begin
        wp_q[j] <= {PW{1'b0}};
        rp_q[j] <= {PW{1'b0}};
        cnt_q[j] <= {(PW+1){1'b0}};
        cr_q[j] <= 10'h000;
      end
    end else begin
      tx_valid <= deq;
      if (deq) begin
        tx_handle <= mem[{sel, rp_q[sel]}];
        tx_class <= sel;
      end
      for (j = 0; j < 4; j = j + 1) begin
        if (enq && enq_class == j[1:0] && !full[j]) begin
          mem[{j[1:0], wp_q[j]}] <= enq_handle;
          wp_q[j] <= wp_q[j] + 1'b1;
        end
        if (deq && sel == j[1:0]) begin
          rp_q[j] <= rp_q[j] + 1'b1;
        end
        cnt_q[j] <= cnt_q[j] + {{PW{1'b0}}, (enq && enq_class == j[1:0] && !full[j])}
                    - {{PW{1'b0}}, (deq && sel == j[1:0])};
        if (deq) begin
          if (reload) begin
            cr_q[j] <= (sel == j[1:0]) ? rl[j] - 10'h001 : rl[j];
          end else if (sel == j[1:0]) begin
            cr_q[j] <= cr_q[j] - 10'h001;
          end
        end
      end
    end
  end
endmodule

// File: stm_mcq.v
`timescale 1ns/1ps
// Remote multicast job queue with optional space held back for IP multicast.
module stm_mcq #(
  parameter HW = 8,
  parameter PW = 3,
  parameter RSV = 2
) (
  // Clock and reset.
  input wire mclk,
  input wire rst_n,
  // Fill side.
  input wire push,
  input wire push_priv,
  input wire rsv_en,
  input wire [HW-1:0] din,
  output wire room,
  // Drain side.
  input wire pop,
  output wire [HW-1:0] dout,
  output wire empty,
  output wire [PW:0] count
);
  localparam DEPTH = 1 << PW;
  localparam [PW:0] L2_LIMIT = DEPTH - RSV;
  reg [HW-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] wp_q;
  reg [PW-1:0] rp_q;
  reg [PW:0] cnt_q;
  wire do_push;
  wire do_pop;

  // Plain multicast stops short of the held-back slots when reservation is on.
  assign room = !cnt_q[PW] && !(rsv_en && !push_priv && cnt_q >= L2_LIMIT);
  assign empty = (cnt_q == {(PW+1){1'b0}});
  assign dout = mem[rp_q];
  assign count = cnt_q;
  assign do_push = push && room;
  assign do_pop = pop && !empty;

  // Jobs wait here until the pipe has a free slot.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= {PW{1'b0}};
      rp_q <= {PW{1'b0}};
      cnt_q <= {(PW+1){1'b0}};
    end else begin
      if (do_push) begin
        mem[wp_q] <= din;
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{PW{1'b0}}, do_push} - {{PW{1'b0}}, do_pop};
    end
  end
endmodule

// File: stm_chk.sv
`timescale 1ns/1ps
// ***********************************
// Port checker for the traffic manager.
// ***********************************
module stm_chk #(
  parameter NP = 12
) (
  // Clock and reset.
  input logic mclk,
  input logic rst_n,
  // Received descriptor.
  input logic rx_valid,
  input logic free_buf_none,
  input logic rx_lookup_hit,
  input logic rx_is_ip,
  input logic [31:0] rx_dst_ip,
  input logic [NP-1:0] rx_dst_ports,
  // Admission result.
  input logic adm_valid,
  input logic [NP-1:0] adm_ports,
  input logic adm_remote,
  input logic adm_drop,
  input logic adm_to_cpu,
  // Transmit and remote pipe.
  input logic [NP-1:0] tx_req,
  input logic [NP-1:0] tx_valid,
  input logic rmt_valid,
  input logic rmt_ready,
  input logic rmt_done
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [2:0] fly_q;
  // Jobs on the pipe not yet finished; kept here so the limit is judged independently.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fly_q <= 3'h0;
    end else begin
      fly_q <= fly_q + {2'h0, rmt_valid & rmt_ready} - {2'h0, rmt_done};
    end
  end
  property p_adm; rx_valid |=> adm_valid; endproperty
  a_adm: assert property (p_adm) else $error("no admission result");
  property p_cause; adm_valid |-> $past(rx_valid); endproperty
  a_cause: assert property (p_cause) else $error("admission without descriptor");
  property p_nobuf; rx_valid && free_buf_none |=> adm_drop && adm_ports == 0 && !adm_remote; endproperty
  a_nobuf: assert property (p_nobuf) else $error("frame kept without buffer");
  property p_sub; rx_valid && rx_lookup_hit |=> (adm_ports & ~$past(rx_dst_ports)) == 0; endproperty
  a_sub: assert property (p_sub) else $error("port outside destination set");
  property p_drop; adm_valid |-> adm_drop == (adm_ports == 0 && !adm_remote); endproperty
  a_drop: assert property (p_drop) else $error("drop flag wrong");
  property p_cpu; rx_valid && rx_is_ip && rx_dst_ip[31:8] == 24'he00000 |=> adm_to_cpu; endproperty
  a_cpu: assert property (p_cpu) else $error("local group frame not sent up");
  property p_tx; (tx_valid & ~$past(tx_req)) == 0; endproperty
  a_tx: assert property (p_tx) else $error("job without request");
  property p_fly; rmt_valid |-> fly_q < 3'h3; endproperty
  a_fly: assert property (p_fly) else $error("too many remote jobs");
endmodule

// File: stm_rmt_model.sv
`timescale 1ns/1ps
// ***********************************
// Remote chip end of the multicast pipe.
// ***********************************
module stm_rmt_model (
  // Clock and reset.
  input logic mclk,
  input logic rst_n,
  // Stall control from the bench.
  input logic hold,
  // Job pipe.
  input logic rmt_valid,
  output logic rmt_ready,
  output logic rmt_done
);
  logic [2:0] busy_q;
  // Jobs are refused while stalled, so the queue behind the pipe can fill.
  assign rmt_ready = !hold;
  // One job finishes every other cycle; a stall holds completions back too.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 3'h0;
      rmt_done <= 1'b0;
    end else begin
      busy_q <= busy_q + {2'h0, rmt_valid & rmt_ready} - {2'h0, rmt_done};
      rmt_done <= !hold && busy_q != 3'h0 && !rmt_done;
    end
  end
endmodule

// File: tb_switch_traffic_manager.sv
`timescale 1ns/1ps
// ***********************************
// Bench for the traffic manager.
// ***********************************
module tb_switch_traffic_manager;
  localparam NP = 12;
  localparam logic [47:0] UC = 48'h0b0000000001;
  localparam logic [47:0] IM = 48'h01005e010203;
  localparam logic [31:0] IP = 32'he0010203;
  // Bench-driven inputs; fields that never vary are tied.
  logic mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, rx_valid = 0, rx_multicast = 0, rx_remote = 0;
  logic free_buf_none = 0, rel_valid = 0, rel_mc = 0, hold = 1, rx_lookup_hit = 1;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0, rx_pcp = 0;
  logic [31:0] haddr = 0, hwdata = 0, rx_dst_ip = 0, rd;
  logic [47:0] rx_dst_mac = 0;
  logic [NP-1:0] rx_dst_ports = 0, rel_ports = 0, tx_req = 0;
  logic [7:0] rx_handle = 0, b;
  wire rx_is_ip = 1'b1;
  wire [7:0] rx_ip_proto = 8'h00;
  wire [NP-1:0] rx_vlan_ports = {NP{1'b1}};
  wire hready, hresp, adm_valid, adm_remote, adm_drop, adm_to_cpu, adm_ip_multicast_frame, rmt_valid, rmt_ready, rmt_done;
  wire [31:0] hrdata;
  wire [1:0] adm_class;
  wire [NP-1:0] adm_ports, tx_valid;
  wire [NP*8-1:0] tx_handle;
  wire [NP*2-1:0] tx_class;
  wire [7:0] rmt_handle;
  int miscompares = 0, n_compared = 0, c;
  int off[4] = '{1, 9, 0, 13};
  int n[4] = '{0, 0, 0, 0};
  int seq[14] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 3, 1, 1, 3};
  stm_top stm_top_inst (.hreadyout(hready), .*);
  stm_rmt_model stm_rmt_model_inst (.*);
  always #25 mclk = ~mclk;
  // Compare and count; four-state equality so an unknown never matches.
  task automatic ck(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single-word transfer; the slave's hready paces both phases.
  task automatic bus(input logic [31:0] a, d, input logic w);
    @(posedge mclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [31:0] a, e);
    bus(a, 0, 0);
    ck(rd, e);
  endtask
  // One descriptor pulse; the result is looked at once its edge has landed.
  task automatic rx(input logic [2:0] p, input logic mc, rm, input logic [NP-1:0] pt, input logic [47:0] mac,
    input logic [31:0] ip);
    @(posedge mclk);
    rx_valid <= 1;
    rx_pcp <= p;
    rx_multicast <= mc;
    rx_remote <= rm;
    rx_dst_ports <= pt;
    rx_dst_mac <= mac;
    rx_dst_ip <= ip;
    rx_handle <= rx_handle + 8'h1;
    @(posedge mclk);
    rx_valid <= 0;
    #1;
  endtask
  task automatic tx(input int p, input logic [7:0] h, input logic [1:0] k);
    @(posedge mclk);
    tx_req[p] <= 1;
    @(posedge mclk);
    tx_req[p] <= 0;
    #1;
    ck(tx_valid[p], 1);
    ck({tx_class[p*2+:2], tx_handle[p*8+:8]}, {k, h});
  endtask
  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1;
    rdc(32'h00, 32'h05af);
    rdc(32'h04, 32'h0112);
    rdc(32'h08, 32'h3020);
    rdc(32'h10, 32'h0820);
    rdc(32'h24, 32'h0);
    rdc(32'h3c, 32'h0);
    $display("reset values done");
    bus(32'h00, 32'h1b1b, 1);
    for (int p = 0; p < 8; p++) begin
      rx(p[2:0], 0, 0, 12'h1 << p, UC, 0);
      ck({adm_class, adm_ports}, {2'(3 - p % 4), 12'(12'h1 << p)});
    end
    for (int p = 0; p < 8; p++) begin
      rdc(32'h40 + 4 * p, 1);
      tx(p, 8'(p + 1), 2'(3 - p % 4));
    end
    @(posedge mclk);
    rel_valid <= 1;
    rel_ports <= 12'h0ff;
    @(posedge mclk);
    rel_valid <= 0;
    rdc(32'h5c, 0);
    free_buf_none <= 1;
    rx(0, 0, 0, 12'h004, UC, 0);
    ck(adm_drop, 1);
    free_buf_none <= 0;
    $display("classes done");
    bus(32'h08, 32'h0302, 1);
    bus(32'h0c, 32'h1, 1);
    for (int i = 0; i < 4; i++) begin
      rx(0, 0, 0, 12'h003, UC, 0);
      ck(adm_ports, i < 2 ? 3 : i < 3 ? 1 : 0);
    end
    bus(32'h08, 32'h3020, 1);
    $display("thresholds done");
    // Backlog on port 11; class 2 stays empty and must be skipped.
    bus(32'h04, 32'h0112, 1);
    b = rx_handle;
    for (int i = 0; i < 14; i++) rx(i < 8 ? 3 : i < 12 ? 2 : 0, 0, 0, 12'h800, UC, 0);
    for (int i = 0; i < 14; i++) begin
      c = seq[i];
      tx(11, 8'(b + off[c] + n[c]), 2'(c));
      n[c]++;
    end
    $display("scheduler done");
    // Pipe stalled: plain multicast fills the remote queue until it refuses.
    for (int i = 0; i < 9; i++) begin
      rx(0, 1, 1, 0, UC, 0);
      ck(adm_remote, i < 8);
    end
    ck(rmt_handle, b + 8'd15);
    hold <= 0;
    do bus(32'h28, 0, 0); while (rd[14:8] !== 0);
    hold <= 1;
    bus(32'h24, 32'h06000000, 1);
    for (int i = 0; i < 7; i++) begin
      rx(0, 1, 1, 0, UC, 0);
      ck(adm_remote, i < 6);
    end
    for (int i = 0; i < 3; i++) begin
      rx(0, 1, 1, 0, IM, IP);
      ck({adm_ip_multicast_frame, adm_remote}, i < 2 ? 3 : 2);
    end
    hold <= 0;
    do bus(32'h28, 0, 0); while (rd[14:8] !== 0);
    $display("remote queue done");
    // Limit set one above what is held: one plain frame fits, then drops.
    bus(32'h24, 0, 1);
    bus(32'h10, {16'h0, 8'h04, rd[7:0] + 8'h1}, 1);
    rx(0, 1, 0, 12'h200, 48'h01005e000001, 32'he0000001);
    ck({adm_to_cpu, adm_drop}, 2);
    rx(0, 1, 0, 12'h200, UC, 0);
    ck(adm_drop, 1);
    rx(0, 1, 0, 12'h200, IM, IP);
    ck(adm_drop, 1);
    bus(32'h24, 32'h02000000, 1);
    rx(0, 1, 0, 12'h200, IM, IP);
    ck(adm_ports, 12'h200);
    rx_lookup_hit <= 0;
    rx(0, 1, 0, 12'h200, IM, IP);
    ck(adm_ports, 12'hfff);
    $display("multicast limit done");
    close_out();
  end
  // Watchdog: the tests need a few hundred cycles.
  initial begin
    #2000000;
    miscompares++;
    close_out();
  end
endmodule
bind stm_top stm_chk #(.NP(NP)) stm_chk_inst (.*);
